/* verilog/dil_converter.sv */
// Converter digital front end: edge latch on update clock, sleep sequencing
`timescale 1ns/1ps
`default_nettype none
module dil_converter (
  input wire logic i_clk,
  input wire logic i_rst,
  dil_if.dac link,
  output dil_pkg::dil_word_t o_primary_code,
  output dil_pkg::dil_word_t o_complementary_code,
  output logic o_current_on,
  output logic o_awake
);

  // Pins from another device pass three flip-flops, and a level counts only
  // once the second and third stages agree, so a one-clock glitch is ignored.
  // Slot 0 carries the update clock, slot 1 the sleep line.
  // Limitation: each update clock level must stand at least two system
  // clocks, which caps the update rate at a quarter of the system clock.
  logic [1:0] pin_raw;
  wire logic [1:0] pin_lvl;
  wire logic [1:0] pin_nxt;

  // The word passes the same depth, so it stays aligned with the clock level
  dil_pkg::dil_word_t d1_q, d1_d;
  dil_pkg::dil_word_t d2_q, d2_d;
  dil_pkg::dil_word_t d3_q, d3_d;

  dil_pkg::dil_word_t master_q, master_d;
  dil_pkg::dil_word_t slave_q, slave_d;
  logic rise;

  dil_pkg::dil_pwr_e pwr_q, pwr_d;
  logic [`DIL_CNT_W-1:0] cnt_q, cnt_d;
  logic sleep_lvl;

  dil_pkg::dil_word_t pri_q, pri_d;
  dil_pkg::dil_word_t comp_q, comp_d;
  logic on_q, on_d;
  logic awake_q, awake_d;

  // Level of a synchronised pin: it moves only when the two oldest stages
  // agree, otherwise the level already held is kept
  function automatic logic dil_agree(input logic [2:0] stages, input logic held);
    logic lvl;
    lvl = held;
    if (stages[2] == stages[1]) begin
      lvl = stages[1];
    end
    return lvl;
  endfunction : dil_agree

  // Current flows, and the converter counts as awake, only when fully powered
  function automatic logic dil_flows(input dil_pkg::dil_pwr_e st);
    return (st == dil_pkg::DIL_ON);
  endfunction : dil_flows

  assign pin_raw = {link.sleep, link.upd_clk}; // [R9] interface supplies the pull-down

  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic [2:0] s_q, s_d;
    logic lvl_q, lvl_d;

    always_comb begin
      s_d = {s_q[1:0], pin_raw[g]};
      lvl_d = dil_agree(s_q, lvl_q);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        s_q <= 3'h0;
        lvl_q <= 1'b0;
      end else begin
        s_q <= s_d;
        lvl_q <= lvl_d;
      end
    end

    assign pin_lvl[g] = lvl_q;
    assign pin_nxt[g] = lvl_d;
  end

  assign sleep_lvl = pin_lvl[1];

  always_comb begin
    d1_d = link.data; // [R1]
    d2_d = d1_q;
    d3_d = d2_q;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
    end else begin
      d1_q <= d1_d;
      d2_q <= d2_d;
      d3_q <= d3_d;
    end
  end

  // The master follows the sampled word while the update clock is low and
  // holds while it is high; the slave copies the master only at the rising
  // edge, so a word that moves during the high phase never reaches the
  // output the way it would through a transparent latch
  always_comb begin
    rise = pin_nxt[0] & ~pin_lvl[0];
    master_d = master_q;
    if (!pin_lvl[0]) begin
      master_d = d3_q; // [R4]
    end
    slave_d = slave_q;
    if (rise) begin
      slave_d = master_d; // [R5]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      master_q <= '0;
      slave_q <= '0;
    end else begin
      master_q <= master_d;
      slave_q <= slave_d;
    end
  end

  // Current is cut as soon as power-down starts; the counters only model
  // how long the compensation node takes to settle. A sleep request during
  // wake-up drops straight back to the off state.
  always_comb begin
    pwr_d = pwr_q;
    cnt_d = cnt_q;
    case (pwr_q)
      dil_pkg::DIL_ON: begin
        if (sleep_lvl) begin
          pwr_d = dil_pkg::DIL_GOING_DOWN; // [R8]
          cnt_d = `DIL_CNT_W'(`DIL_DOWN_CYC);
        end
      end
      dil_pkg::DIL_GOING_DOWN: begin
        if (cnt_q <= `DIL_CNT_W'(1)) begin
          pwr_d = dil_pkg::DIL_OFF; // [R10]
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      dil_pkg::DIL_OFF: begin
        if (!sleep_lvl) begin
          pwr_d = dil_pkg::DIL_WAKING;
          cnt_d = `DIL_CNT_W'(`DIL_UP_CYC);
        end
      end
      dil_pkg::DIL_WAKING: begin
        if (sleep_lvl) begin
          pwr_d = dil_pkg::DIL_OFF;
        end else if (cnt_q <= `DIL_CNT_W'(1)) begin
          pwr_d = dil_pkg::DIL_ON; // [R10]
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        pwr_d = dil_pkg::DIL_ON;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_q <= dil_pkg::DIL_ON;
      cnt_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      cnt_q <= cnt_d;
    end
  end

  // Codes and the current flag are registered from the next state so that
  // they always change on the same edge; the complementary code carries the
  // share of full scale that the primary code leaves
  always_comb begin
    on_d = dil_flows(pwr_d); // [R8]
    awake_d = dil_flows(pwr_d);
    pri_d = '0;
    comp_d = '0;
    if (on_d) begin
      pri_d = slave_d; // [R1] [R2]
      comp_d = `DIL_FULL_SCALE ^ slave_d; // [R3]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_q <= 1'b1;
      awake_q <= 1'b1;
      pri_q <= '0;
      comp_q <= `DIL_FULL_SCALE;
    end else begin
      on_q <= on_d;
      awake_q <= awake_d;
      pri_q <= pri_d;
      comp_q <= comp_d;
    end
  end

  assign o_primary_code = pri_q;
  assign o_complementary_code = comp_q;
  assign o_current_on = on_q;
  assign o_awake = awake_q;
endmodule : dil_converter
`default_nettype wire

/* inc/dil_cfg.svh */
// Constants for the converter input latch and sleep link
// Operation
// [R1] Data is 14-bit unsigned binary, MSB highest
// [R2] All ones gives full-scale primary current
// [R3] Complementary output carries the remaining current
// [R4] Capture data with edge-triggered master-slave latch
// [R5] Update output after each rising clock edge
// [R6] Source clock pulse widths meet latch minimum
// [R7] Source changes data on falling clock edge
// [R8] Sleep high powers down, output current off
// [R9] Sleep pulled down, unconnected means enabled
// [R10] Power down under 5 us, up 3.25 ms
// [R11] No sleep with external control amplifier overdrive
// [R12] Source treats output invalid during power-up
`ifndef DIL_CFG_SVH
`define DIL_CFG_SVH
`define DIL_DATA_W 14
`define DIL_FULL_SCALE 14'h3fff
`define DIL_CLK_NS 10
`define DIL_DOWN_NS 5000
`define DIL_UP_NS 3250000
`define DIL_DOWN_CYC (`DIL_DOWN_NS / `DIL_CLK_NS)
`define DIL_UP_CYC (`DIL_UP_NS / `DIL_CLK_NS)
`define DIL_CNT_W 22
// Half period of the update clock in system clocks; the pin filter needs two
`define DIL_DIV_HALF 2
`endif

/* inc/dil_pkg.sv */
// Types shared by both ends of the converter link
`include "dil_cfg.svh"
package dil_pkg;
  typedef logic [`DIL_DATA_W-1:0] dil_word_t;
  typedef enum logic [1:0] {DIL_ON, DIL_GOING_DOWN, DIL_OFF, DIL_WAKING} dil_pwr_e;
endpackage : dil_pkg

/* inc/dil_if.sv */
// Parallel data, update clock and sleep wires between source and converter
`timescale 1ns/1ps
`default_nettype none
interface dil_if;
  dil_pkg::dil_word_t data;
  logic upd_clk;
  logic sleep_out;
  logic sleep_oe_n;
  logic sleep;
  // Pull-down when the source does not drive the sleep line
  assign sleep = sleep_oe_n ? 1'b0 : sleep_out;
  modport src (output data, output upd_clk, output sleep_out, output sleep_oe_n);
  modport dac (input data, input upd_clk, input sleep);
endinterface : dil_if
`default_nettype wire

/* verilog/dil_source.sv */
// Data source end: divided update clock, falling-edge data launch, sleep control
`timescale 1ns/1ps
`default_nettype none
module dil_source (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dil_pkg::dil_word_t i_word,
  input wire logic i_sleep_req,
  input wire logic i_sleep_float,
  input wire logic i_ext_amp,
  output logic o_word_ready,
  output logic o_out_valid,
  dil_if.src link
);
  logic clk_q, clk_d;
  logic [3:0] div_q, div_d;
  logic turn;
  dil_pkg::dil_word_t data_q, data_d;
  logic sleep_q, sleep_d;
  logic float_q, float_d;
  logic [`DIL_CNT_W-1:0] wait_q, wait_d;
  logic valid_q, valid_d;

  // Word taken in the last clock of the high phase, just before the link clock falls
  assign o_word_ready = clk_q & turn;

  always_comb begin
    turn = (div_q == 4'(`DIL_DIV_HALF - 1));
    div_d = turn ? 4'h0 : div_q + 4'h1;
    clk_d = turn ? ~clk_q : clk_q; // [R6] 50% duty keeps both pulse widths equal
    data_d = data_q;
    if (clk_q && turn) begin
      data_d = i_word; // [R7]
    end
    // Both sleep wires are registered so the line cannot glitch when they change together
    sleep_d = i_sleep_req & ~i_ext_amp; // [R11]
    float_d = i_sleep_float;
    wait_d = wait_q;
    valid_d = valid_q;
    if (sleep_q) begin
      valid_d = 1'b0;
      wait_d = `DIL_CNT_W'(`DIL_UP_CYC);
    end else if (wait_q != '0) begin
      wait_d = wait_q - 1'b1; // [R12]
    end else begin
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_q <= 1'b0;
      div_q <= 4'h0;
      data_q <= '0;
      sleep_q <= 1'b0;
      float_q <= 1'b0;
      wait_q <= `DIL_CNT_W'(`DIL_UP_CYC);
      valid_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      div_q <= div_d;
      data_q <= data_d;
      sleep_q <= sleep_d;
      float_q <= float_d;
      wait_q <= wait_d;
      valid_q <= valid_d;
    end
  end

  assign link.upd_clk = clk_q;
  assign link.data = data_q; // [R1]
  assign link.sleep_out = sleep_q;
  assign link.sleep_oe_n = float_q;
  assign o_out_valid = valid_q;
endmodule : dil_source
`default_nettype wire

/* verification/dil_monitor.sv */
// Checker on the link wires and the converter outputs
`timescale 1ns/1ps
`default_nettype none
module dil_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dil_pkg::dil_word_t data,
  input wire logic upd_clk,
  input wire logic sleep_oe_n,
  input wire logic sleep,
  input wire logic o_current_on,
  input wire dil_pkg::dil_word_t o_primary_code,
  input wire dil_pkg::dil_word_t o_complementary_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Each phase of the update clock stands two system clocks, the source's half period
  a_clk_high_len: assert property ($rose(upd_clk) |-> upd_clk [*2] ##1 !upd_clk)
    else $error("clk high");
  a_clk_low_len: assert property ($fell(upd_clk) |-> !upd_clk [*2] ##1 upd_clk)
    else $error("clk low");
  a_data_on_fall: assert property (!$stable(data) |-> $fell(upd_clk)) else $error("data");
  a_data_at_rise: assert property ($rose(upd_clk) |-> $stable(data)) else $error("rise");
  a_sleep_pull_down: assert property (sleep_oe_n |-> !sleep) else $error("pull");
  a_comp_sum: assert property (o_current_on |->
    (o_complementary_code ^ o_primary_code) == 14'h3fff) else $error("comp");
  a_off_zero: assert property (!o_current_on |->
    (o_primary_code | o_complementary_code) == 14'h0) else $error("off");
  // A one-clock pulse is filtered out by the converter's pin stages
  a_sleep_cuts: assert property ($rose(sleep) ##1 sleep |-> ##[1:8] !o_current_on)
    else $error("cut");
endmodule : dil_monitor
`default_nettype wire

/* verification/testbench.sv */
// Source and converter joined by the link, driven from the user sides
`timescale 1ns/1ps
`default_nettype none
`include "dil_cfg.svh"
module testbench;
  logic i_clk = 0, i_rst = 1, i_sleep_req = 0, i_sleep_float = 0, i_ext_amp = 0;
  logic rdy, valid, cur, awake;
  dil_pkg::dil_word_t i_word = 14'h0, pri, cpl;
  int failures = 0, checks = 0;
  dil_if link ();
  dil_source i_dil_source (.i_clk(i_clk), .i_rst(i_rst), .i_word(i_word),
    .i_sleep_req(i_sleep_req), .i_sleep_float(i_sleep_float), .i_ext_amp(i_ext_amp),
    .o_word_ready(rdy), .o_out_valid(valid), .link(link.src));
  dil_converter i_dil_converter (.i_clk(i_clk), .i_rst(i_rst), .link(link.dac),
    .o_primary_code(pri), .o_complementary_code(cpl), .o_current_on(cur), .o_awake(awake));
  dil_monitor i_dil_monitor (.i_clk(i_clk), .i_rst(i_rst), .data(link.data),
    .upd_clk(link.upd_clk), .sleep_oe_n(link.sleep_oe_n), .sleep(link.sleep),
    .o_current_on(cur), .o_primary_code(pri), .o_complementary_code(cpl));
  initial forever #5 i_clk = ~i_clk;
  task automatic cmp(string n, logic [13:0] e, logic [13:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Word held for 12 clocks: three update periods, so three ready pulses pass
  task automatic send(dil_pkg::dil_word_t w);
    logic [13:0] n;
    n = '0;
    @(posedge i_clk);
    i_word <= w;
    repeat (12) begin
      @(negedge i_clk);
      n = n + 14'(rdy);
    end
    cmp("ready", 14'(12 / (2 * `DIL_DIV_HALF)), n);
    cmp("primary", w, pri);
    cmp("compl", w ^ 14'h3fff, cpl);
  endtask : send
  task automatic ctl(logic r, logic f, logic a, int n);
    @(posedge i_clk);
    i_sleep_req <= r;
    i_sleep_float <= f;
    i_ext_amp <= a;
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : ctl
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 0;
    send(14'h3fff);
    send(14'h2000);
    send(14'h0001);
    send(14'h1555);
    $display("data test done");
    ctl(1, 1, 0, 6);
    cmp("float", 14'h0, 14'(link.sleep));
    ctl(1, 0, 1, 6);
    cmp("amp", 14'h0, 14'(link.sleep));
    cmp("on", 14'h1, 14'(cur));
    ctl(1, 0, 0, 520);
    cmp("off", 14'h0, 14'(cur));
    cmp("slept", 14'h0, pri);
    ctl(0, 0, 0, 20);
    cmp("awake", 14'h0, 14'(awake));
    cmp("valid", 14'h0, 14'(valid));
    $display("sleep test done");
    close_out();
  end
  initial begin
    #20000;
    failures++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
